// file: src/rcc_pkg.sv
// Purpose: Shared constants and types for the reset cause collector
// Assumes: 32-bit APB data, 16-bit cause register in the low half
// Notes: Offsets are byte addresses of aligned words
package rcc_pkg;
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFF_STATUS = 12'h000;
    localparam logic [11:0] OFF_LIVE = 12'h004;

    // Cause register field positions
    localparam int unsigned BIT_POR = 0;
    localparam int unsigned BIT_BOR = 1;
    localparam int unsigned BIT_IDLE = 2;
    localparam int unsigned BIT_SLEEP = 3;
    localparam int unsigned BIT_WATCHDOG_TIMEOUT_FLAG = 4;
    localparam int unsigned BIT_SOFT_WATCHDOG_ENABLE = 5;
    localparam int unsigned BIT_SWR = 6;
    localparam int unsigned BIT_EXTERNAL_PIN_FLAG = 7;
    localparam int unsigned BIT_SLEEP_REGULATOR_KEEP = 8;
    localparam int unsigned BIT_CM = 9;
    localparam int unsigned BIT_VREGSF = 11;
    localparam int unsigned BIT_IOPU = 14;
    localparam int unsigned BIT_TRAP = 15;

    localparam logic [15:0] STATUS_POR_VAL = 16'h0003;
    localparam logic [15:0] STATUS_MASK = 16'hCBFF;
    localparam logic [1:0] WDT_CFG_UNPROG = 2'h3;
    localparam logic [2:0] OSC_RESET_VAL = 3'h0;

    // Reset request sources, all active high levels or pulses
    typedef struct packed {
        logic brownout;
        logic master_clear;
        logic soft_reset;
        logic watchdog_timeout;
        logic config_mismatch;
        logic trap_conflict;
        logic illegal_opcode;
        logic uninit_w_pointer;
        logic security_violation;
    } rcc_src_t;

    // Power state events, one-cycle pulses on wake-up
    typedef struct packed {
        logic sleep_wake;
        logic idle_wake;
    } rcc_pwr_t;
endpackage : rcc_pkg

// file: src/rcc_reset_cause_collector.sv
// Purpose: Combines reset sources into one system reset, records cause
// Assumes: presetn is the power-on reset; sources synchronous to pclk
// Notes: Cause register at 0x000, live status at 0x004, zero wait states
//
// Overview of operation
// - Any active source asserts system reset output
// - Accept all nine reset source kinds
// - Each reset kind sets a flag; the three illegal kinds share bit 14
// - Power-on clears register, sets bits one, zero
// - Software sets/clears bits; no reset results
// - Every reset loads fuse oscillator select
// - Trap conflict resets, sets bit 15
// - Illegal opcode/pointer/security resets, sets flag
// - External pin reset sets bit 7
// - Reset instruction resets, sets bit 6
// - Watchdog time-out sets bit 4
// - Bit 5 enables or disables watchdog
// - Unprogrammed watchdog config forces watchdog on
// - Wake from Sleep sets bit 3
// - Wake from Idle sets bit 2
// - Brown-out reset sets bit 1
// - Power-on reset sets bit 0
// - Bit 8 keeps regulator active in Sleep
`timescale 1ns/1ps
module rcc_reset_cause_collector #(
    parameter int unsigned ADDR_W = rcc_pkg::ADDR_W
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire rcc_pkg::rcc_src_t reset_src,
    input wire rcc_pkg::rcc_pwr_t pwr_evt,
    input wire logic [2:0] fuse_osc_select,
    input wire logic [1:0] watchdog_config_field,
    output logic system_reset_out,
    output logic [2:0] new_osc_select,
    output logic watchdog_enable,
    output logic sleep_regulator_keep,
    output logic flash_regulator_keep
);

    logic [15:0] status;
    logic [15:0] next_status;
    logic [15:0] set_mask;
    logic por_pending;
    logic src_any;
    logic illegal_any;
    logic wr_status;
    logic rd_setup;
    logic [31:0] next_rdata;

    // Decode of a word address against a register offset
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a,
                                      input logic [11:0] off);
        addr_hit = (a[ADDR_W-1:2] == off[ADDR_W-1:2]);
    endfunction : addr_hit

    function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
        addr_mapped = addr_hit(a, rcc_pkg::OFF_STATUS) ||
                      addr_hit(a, rcc_pkg::OFF_LIVE);
    endfunction : addr_mapped

    // Illegal-condition group
    assign illegal_any = reset_src.illegal_opcode |
                         reset_src.uninit_w_pointer |
                         reset_src.security_violation;

    assign src_any = |reset_src;

    // Power-on pending until first edge after release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            por_pending <= 1'b1;
        end else begin
            por_pending <= 1'b0;
        end
    end

    // System reset: held through power-on, follows any source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            system_reset_out <= 1'b1;
        end else begin
            system_reset_out <= src_any;
        end
    end

    // Fuse oscillator select loaded on every reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            new_osc_select <= rcc_pkg::OSC_RESET_VAL;
        end else if (por_pending || src_any) begin
            new_osc_select <= fuse_osc_select;
        end
    end

    // Hardware set events, one flag per source; the three illegal sources share bit 14
    always_comb begin
        set_mask = 16'h0000;
        set_mask[rcc_pkg::BIT_TRAP] = reset_src.trap_conflict;
        set_mask[rcc_pkg::BIT_IOPU] = illegal_any;
        set_mask[rcc_pkg::BIT_CM] = reset_src.config_mismatch;
        set_mask[rcc_pkg::BIT_EXTERNAL_PIN_FLAG] = reset_src.master_clear;
        set_mask[rcc_pkg::BIT_SWR] = reset_src.soft_reset;
        set_mask[rcc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG] = reset_src.watchdog_timeout;
        set_mask[rcc_pkg::BIT_SLEEP] = pwr_evt.sleep_wake;
        set_mask[rcc_pkg::BIT_IDLE] = pwr_evt.idle_wake;
        set_mask[rcc_pkg::BIT_BOR] = reset_src.brownout;
    end

    assign wr_status = psel && penable && pwrite &&
                       addr_hit(paddr, rcc_pkg::OFF_STATUS);
    assign rd_setup = psel && !penable && !pwrite;

    // Software write by byte lane, then hardware set wins
    always_comb begin
        next_status = status;
        if (wr_status) begin
            if (pstrb[0]) begin
                next_status[7:0] = pwdata[7:0];
            end
            if (pstrb[1]) begin
                next_status[15:8] = pwdata[15:8];
            end
        end
        next_status = (next_status | set_mask) & rcc_pkg::STATUS_MASK;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= rcc_pkg::STATUS_POR_VAL;
        end else begin
            status <= next_status;
        end
    end

    // Watchdog enable: software bit or unprogrammed configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            watchdog_enable <= 1'b0;
        end else begin
            watchdog_enable <= status[rcc_pkg::BIT_SOFT_WATCHDOG_ENABLE] ||
                (watchdog_config_field == rcc_pkg::WDT_CFG_UNPROG);
        end
    end

    assign sleep_regulator_keep = status[rcc_pkg::BIT_SLEEP_REGULATOR_KEEP];
    assign flash_regulator_keep = status[rcc_pkg::BIT_VREGSF];

    // APB read data captured in setup phase
    always_comb begin
        next_rdata = 32'h00000000;
        if (addr_hit(paddr, rcc_pkg::OFF_STATUS)) begin
            next_rdata = {16'h0000, status};
        end else if (addr_hit(paddr, rcc_pkg::OFF_LIVE)) begin
            next_rdata = {16'h0000, 3'h0, new_osc_select, reset_src,
                          watchdog_enable};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (rd_setup) begin
            prdata <= next_rdata;
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel && penable && (!addr_mapped(paddr) ||
                     (pwrite && addr_hit(paddr, rcc_pkg::OFF_LIVE)));

    // Checks
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_rst_assert;
        src_any |=> system_reset_out;
    endproperty
    a_rst_assert: assert property (p_rst_assert)
        else $error("system reset not asserted by source");

    property p_rst_release;
        !src_any |=> !system_reset_out;
    endproperty
    a_rst_release: assert property (p_rst_release)
        else $error("system reset without source");

    property p_por_value;
        por_pending |-> status == rcc_pkg::STATUS_POR_VAL;
    endproperty
    a_por_value: assert property (p_por_value)
        else $error("power-on cause value wrong");

    property p_sw_write;
        wr_status && !src_any && !(|pwr_evt) && (pstrb[1:0] == 2'h3)
            |=> status == ($past(pwdata[15:0]) & rcc_pkg::STATUS_MASK);
    endproperty
    a_sw_write: assert property (p_sw_write)
        else $error("software write not stored");

    property p_sw_noreset;
        wr_status && !src_any |=> !system_reset_out;
    endproperty
    a_sw_noreset: assert property (p_sw_noreset)
        else $error("software write caused reset");

    property p_osc_load;
        src_any |=> new_osc_select == $past(fuse_osc_select);
    endproperty
    a_osc_load: assert property (p_osc_load)
        else $error("oscillator select not loaded");

    property p_trap;
        reset_src.trap_conflict |=> status[rcc_pkg::BIT_TRAP] &&
            system_reset_out;
    endproperty
    a_trap: assert property (p_trap)
        else $error("trap flag not set");

    property p_illegal;
        illegal_any |=> status[rcc_pkg::BIT_IOPU];
    endproperty
    a_illegal: assert property (p_illegal)
        else $error("illegal flag not set");

    property p_ext;
        reset_src.master_clear |=> status[rcc_pkg::BIT_EXTERNAL_PIN_FLAG];
    endproperty
    a_ext: assert property (p_ext)
        else $error("external pin flag not set");

    property p_swr;
        reset_src.soft_reset |=> status[rcc_pkg::BIT_SWR] &&
            system_reset_out;
    endproperty
    a_swr: assert property (p_swr)
        else $error("soft reset flag or reset missing");

    property p_watchdog_timeout_flag;
        reset_src.watchdog_timeout |=> status[rcc_pkg::BIT_WATCHDOG_TIMEOUT_FLAG];
    endproperty
    a_watchdog_timeout_flag: assert property (p_watchdog_timeout_flag)
        else $error("watchdog flag not set");

    property p_wdt_en;
        (watchdog_config_field != rcc_pkg::WDT_CFG_UNPROG)
            |=> watchdog_enable == $past(status[rcc_pkg::BIT_SOFT_WATCHDOG_ENABLE]);
    endproperty
    a_wdt_en: assert property (p_wdt_en)
        else $error("watchdog enable not following bit");

    property p_wdt_forced;
        (watchdog_config_field == rcc_pkg::WDT_CFG_UNPROG)
            |=> watchdog_enable;
    endproperty
    a_wdt_forced: assert property (p_wdt_forced)
        else $error("watchdog not forced on");

    property p_sleep;
        pwr_evt.sleep_wake |=> status[rcc_pkg::BIT_SLEEP];
    endproperty
    a_sleep: assert property (p_sleep)
        else $error("sleep flag not set");

    property p_idle;
        pwr_evt.idle_wake |=> status[rcc_pkg::BIT_IDLE];
    endproperty
    a_idle: assert property (p_idle)
        else $error("idle flag not set");

    property p_bor;
        reset_src.brownout |=> status[rcc_pkg::BIT_BOR];
    endproperty
    a_bor: assert property (p_bor)
        else $error("brown-out flag not set");

    property p_vreg;
        wr_status && pstrb[1] |=>
            sleep_regulator_keep == $past(pwdata[rcc_pkg::BIT_SLEEP_REGULATOR_KEEP]);
    endproperty
    a_vreg: assert property (p_vreg)
        else $error("regulator keep bit not written");

    property p_accumulate;
        !wr_status |=> (status & $past(status)) == $past(status);
    endproperty
    a_accumulate: assert property (p_accumulate)
        else $error("cause flag lost without write");

    property p_cm;
        reset_src.config_mismatch |=> status[rcc_pkg::BIT_CM];
    endproperty
    a_cm: assert property (p_cm)
        else $error("config mismatch flag not set");

    property p_por_sro;
        por_pending |-> system_reset_out;
    endproperty
    a_por_sro: assert property (p_por_sro)
        else $error("system reset dropped during power-on");

    property p_por_osc;
        por_pending |=> new_osc_select == $past(fuse_osc_select);
    endproperty
    a_por_osc: assert property (p_por_osc)
        else $error("oscillator select not loaded at power-on");

    property p_osc_hold;
        !por_pending && !src_any |=> $stable(new_osc_select);
    endproperty
    a_osc_hold: assert property (p_osc_hold)
        else $error("oscillator select changed without reset");

    property p_reserved;
        (status & ~rcc_pkg::STATUS_MASK) == 16'h0000;
    endproperty
    a_reserved: assert property (p_reserved)
        else $error("reserved cause bit set");

    property p_por_flag;
        !wr_status |=> !$rose(status[rcc_pkg::BIT_POR]);
    endproperty
    a_por_flag: assert property (p_por_flag)
        else $error("power-on flag set without power-on");

    property p_sw_clear;
        wr_status && pstrb[0] && !(|set_mask)
            |=> status[rcc_pkg::BIT_POR] == $past(pwdata[rcc_pkg::BIT_POR]);
    endproperty
    a_sw_clear: assert property (p_sw_clear)
        else $error("software clear of flag not stored");

    property p_rd_status;
        rd_setup && addr_hit(paddr, rcc_pkg::OFF_STATUS)
            |=> prdata == {16'h0000, $past(status)};
    endproperty
    a_rd_status: assert property (p_rd_status)
        else $error("cause register read data wrong");

    property p_live_ro;
        psel && penable && pwrite && addr_hit(paddr, rcc_pkg::OFF_LIVE)
            |-> pslverr;
    endproperty
    a_live_ro: assert property (p_live_ro)
        else $error("write to live status not refused");

    property p_multi;
        reset_src.brownout && reset_src.trap_conflict
            |=> status[rcc_pkg::BIT_BOR] && status[rcc_pkg::BIT_TRAP];
    endproperty
    a_multi: assert property (p_multi)
        else $error("simultaneous sources not all recorded");

    property p_wdt_off;
        !status[rcc_pkg::BIT_SOFT_WATCHDOG_ENABLE] &&
            (watchdog_config_field != rcc_pkg::WDT_CFG_UNPROG)
            |=> !watchdog_enable;
    endproperty
    a_wdt_off: assert property (p_wdt_off)
        else $error("watchdog enabled while disabled");

    property p_set_wins;
        wr_status && reset_src.master_clear |=> status[rcc_pkg::BIT_EXTERNAL_PIN_FLAG];
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("software write beat hardware set");

    // Main scenarios
    c_trap: cover property (reset_src.trap_conflict ##1 system_reset_out);
    c_wdt_forced: cover property (
        watchdog_config_field == rcc_pkg::WDT_CFG_UNPROG ##1 watchdog_enable);
    c_sw_clear: cover property (wr_status && pwdata[15:0] == 16'h0000);
    c_sleep: cover property (pwr_evt.sleep_wake ##1 status[3]);
    c_set_clear: cover property (wr_status && |set_mask);

endmodule : rcc_reset_cause_collector

// file: bench/rcc_reset_cause_collector_tb_top.sv
// Purpose: Self-checking bench for the reset cause collector
// Assumes: zero-wait APB slave, sources sampled on pclk
// Notes: Registers are reached only through the APB task
`timescale 1ns/1ps
module rcc_reset_cause_collector_tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0] pstrb;
    logic sro, wd_en, slp_keep, fl_keep;
    rcc_pkg::rcc_src_t reset_src;
    rcc_pkg::rcc_pwr_t pwr_evt;
    logic [2:0] fuse_osc_select, new_osc_select;
    logic [1:0] watchdog_config_field;
    logic [15:0] exp_st;
    int bad_count, checks_done;
    // Cause flag position for source struct bits 8 down to 0
    int unsigned flag_pos [9] = '{1, 7, 6, 4, 9, 15, 14, 14, 14};

    rcc_reset_cause_collector u_rcc_reset_cause_collector (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .reset_src(reset_src), .pwr_evt(pwr_evt),
        .fuse_osc_select(fuse_osc_select),
        .watchdog_config_field(watchdog_config_field),
        .system_reset_out(sro), .new_osc_select(new_osc_select),
        .watchdog_enable(wd_en), .sleep_regulator_keep(slp_keep),
        .flash_regulator_keep(fl_keep)
    );

    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : tally_and_finish

    task automatic ck(input string name, input logic [31:0] seen,
                      input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask : ck

    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (pready !== 1'b1) begin
            bad_count++;
            $display("Error pready expected 1 seen %b", pready);
            tally_and_finish();
        end else begin
            r = prdata;
            e = pslverr;
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask : apb

    // One-cycle source pulse, then reset output and clock select checks
    task automatic src_pulse(input logic [8:0] v);
        @(posedge pclk);
        reset_src <= rcc_pkg::rcc_src_t'(v);
        @(posedge pclk);
        reset_src <= '0;
        @(negedge pclk);
        ck("system_reset_out", {31'h0, sro}, 32'h1);
        ck("new_osc_select", {29'h0, new_osc_select}, {29'h0, fuse_osc_select});
        @(negedge pclk);
        ck("system_reset_out", {31'h0, sro}, 32'h0);
    endtask : src_pulse

    task automatic settle2();
        @(posedge pclk);
        @(posedge pclk);
        @(negedge pclk);
    endtask : settle2

    initial begin
        bad_count = 0;
        checks_done = 0;
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = '0;
        pwdata = '0;
        pstrb = '0;
        reset_src = '0;
        pwr_evt = '0;
        fuse_osc_select = 3'h5;
        watchdog_config_field = 2'h0;
        repeat (4) @(posedge pclk);
        @(negedge pclk);
        ck("system_reset_out", {31'h0, sro}, 32'h1);
        @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        @(negedge pclk);
        ck("new_osc_select", {29'h0, new_osc_select}, 32'h5);
        apb(1'b0, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
        ck("status", rd, 32'h0003);
        apb(1'b0, rcc_pkg::OFF_LIVE, 32'h0, rd, err);
        ck("live", rd, 32'h00001400);
        apb(1'b1, rcc_pkg::OFF_STATUS, 32'h0000FFFF, rd, err);
        apb(1'b0, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
        ck("status", rd, 32'h0000CBFF);
        ck("flash_regulator_keep", {31'h0, fl_keep}, 32'h1);
        ck("system_reset_out", {31'h0, sro}, 32'h0);
        apb(1'b1, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
        exp_st = 16'h0;
        for (int i = 0; i < 9; i++) begin
            fuse_osc_select <= i[2:0];
            src_pulse(9'h100 >> i);
            exp_st[flag_pos[i]] = 1'b1;
            apb(1'b0, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
            ck("status", rd, {16'h0, exp_st});
        end
        ck("status", rd, 32'h0000C2D2);
        ck("status", rd, 32'h0000C2D2);
        apb(1'b1, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
        src_pulse(9'h1FF);
        apb(1'b0, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
        ck("status", rd, 32'h0000C2D2);
        apb(1'b1, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
        @(posedge pclk);
        pwr_evt <= 2'b10;
        @(posedge pclk);
        pwr_evt <= 2'b01;
        @(posedge pclk);
        pwr_evt <= 2'b00;
        apb(1'b0, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
        ck("status", rd, 32'h000C);
        ck("system_reset_out", {31'h0, sro}, 32'h0);
        apb(1'b1, rcc_pkg::OFF_STATUS, 32'h0120, rd, err);
        settle2();
        ck("watchdog_enable", {31'h0, wd_en}, 32'h1);
        ck("sleep_regulator_keep", {31'h0, slp_keep}, 32'h1);
        apb(1'b1, rcc_pkg::OFF_STATUS, 32'h8000, rd, err);
        settle2();
        ck("watchdog_enable", {31'h0, wd_en}, 32'h0);
        ck("sleep_regulator_keep", {31'h0, slp_keep}, 32'h0);
        ck("system_reset_out", {31'h0, sro}, 32'h0);
        @(posedge pclk);
        watchdog_config_field <= rcc_pkg::WDT_CFG_UNPROG;
        settle2();
        ck("watchdog_enable", {31'h0, wd_en}, 32'h1);
        @(posedge pclk);
        watchdog_config_field <= 2'h2;
        settle2();
        ck("watchdog_enable", {31'h0, wd_en}, 32'h0);
        apb(1'b1, rcc_pkg::OFF_LIVE, 32'h0, rd, err);
        ck("pslverr", {31'h0, err}, 32'h1);
        apb(1'b0, 12'h010, 32'h0, rd, err);
        ck("pslverr", {31'h0, err}, 32'h1);
        ck("prdata", rd, 32'h0);
        @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        presetn <= 1'b1;
        apb(1'b0, rcc_pkg::OFF_STATUS, 32'h0, rd, err);
        ck("status", rd, 32'h0003);
        tally_and_finish();
    end
endmodule : rcc_reset_cause_collector_tb_top
